// ==== logic/iee_regs.svh ====
// Offsets, field positions and reset values of the interrupt entry block
`ifndef IEE_REGS_SVH
`define IEE_REGS_SVH
// Ring 0 page zero word addresses
`define IEE_ADDR_LEVEL 32'h0000_0004
`define IEE_ADDR_VEC_A 32'h0000_0008
`define IEE_ADDR_VEC_B 32'h0000_0010
`define IEE_ADDR_ISP 32'h0000_0020
`define IEE_ADDR_PREV_SP 32'h0000_002C
`define IEE_ADDR_PROC_SP 32'h0000_0048
// Field values
`define IEE_FRL_EXT 2'h1
`define IEE_LEVEL_BASE 16'h0000
`define IEE_LEVEL_ONE 16'h0001
`define IEE_TGT_ANY 3'h7
`define IEE_TGT_RST 3'h7
`define IEE_EN_RST 16'h0000
`define IEE_ICR_RST 64'h0000_0000_0000_0000
`define IEE_MODE_HI 39
`define IEE_MODE_LO 32
`define IEE_CII_HI 2
`define IEE_CII_LO 0
`define IEE_RT_BIT 3'h2
`endif

// ==== logic/iee_pkg.sv ====
// Types of the interrupt entry block
package iee_pkg;
    typedef enum logic [8:0] {
        IEE_IDLE = 9'h001,
        IEE_RING = 9'h002,
        IEE_LVL_RD = 9'h004,
        IEE_LVL_WR = 9'h008,
        IEE_PUSH = 9'h010,
        IEE_SAVE_SP = 9'h020,
        IEE_LOAD_SP = 9'h040,
        IEE_VEC = 9'h080,
        IEE_DONE = 9'h100
    } iee_state_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } iee_mem_req_t;
    typedef struct packed {
        logic [2:0] op;
        logic [63:0] data;
    } iee_cfg_wr_t;
endpackage

// ==== logic/iee_target_pick.sv ====
// Chooses the CPU that takes a pending channel
`timescale 1ns/100ps
module iee_target_pick
    import iee_pkg::*;
#(
    parameter int NCPU = 4
)
(
    input wire logic [2:0] target_sel,
    input wire logic [NCPU-1:0] chan_local_en,
    input wire logic [NCPU-1:0] cpu_idle,
    output logic [NCPU-1:0] grant
);
    `include "iee_regs.svh"
    logic [NCPU-1:0] cand;
    logic [NCPU-1:0] fixed;
    assign cand = chan_local_en & cpu_idle;
    // Lowest index wins, so CPU 0 when all qualify
    always_comb
    begin
        grant = '0;
        fixed = '0;
        for (int i = NCPU - 1; i >= 0; i--)
        begin
            if (cand[i])
            begin
                grant = '0;
                grant[i] = 1'b1;
            end
            if (target_sel == 3'(i))
            begin
                fixed[i] = chan_local_en[i];
            end
        end
        if (target_sel != `IEE_TGT_ANY)
        begin
            grant = fixed;
        end
    end
endmodule

// ==== logic/iee_entry.sv ====
// Interrupt entry sequencer with complex enable flags and registers
`timescale 1ns/100ps
// Notes on behaviour
// - Taking an interrupt clears the on flag
// - Level halfword zero means base level
// - Base ring 0: frame length 01, push, clear status
// - Save SP to previous slot, load interrupt SP
// - Outside ring 0 base: ring crossing first
// - Interrupt level: cross, push, no stack switch
// - Handler address from one of two vectors
// - Channel id: 29 zeros, 3-bit channel
// - Process stack pointer word never written
// - Channel pending reset once processor responds
// - Complex on flag; clear flag defers all
// - Disable returns previous flag state atomically
// - Realtime flag used in realtime mode
// - Eight-bit local and global enables per channel
// - Write ops update local or global enable
// - Realtime variant: 16-bit enables, mode picks half
// - Realtime channels map to enable bits 8..15
// - Three-bit target CPU, all ones any
// - Control register: delivery mode, comm set
// - Level fetched and incremented, not interruptible
// - Any-target delivers to idle enabled CPU
module iee_entry
    import iee_pkg::*;
#(
    parameter int NCPU = 4,
    parameter int MY_CPU = 0,
    parameter bit REALTIME = 1'b1
)
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic CLK_EN,
    // Channel requests and CPU state
    input wire logic [15:0] CHAN_PEND,
    input wire logic [NCPU-1:0] CPU_IDLE,
    input wire logic [NCPU-1:0][15:0] PEER_LOCAL_EN,
    input wire logic RT_MODE,
    input wire logic [1:0] CUR_RING,
    input wire logic [31:0] CUR_SP,
    output logic [15:0] CHAN_ACK,
    // Flag and register instructions
    input wire logic ENI,
    input wire logic DSI,
    output logic DSI_PREV,
    input wire iee_cfg_wr_t CFG_WR,
    output logic [15:0] LOCAL_EN,
    output logic [15:0] GLOBAL_EN,
    output logic [2:0] TARGET_CPU,
    output logic [63:0] INTERRUPT_CHANNEL_CONTROL,
    output logic COMPLEX_IRQ_ON_FLAG,
    output logic REALTIME_IRQ_ON_FLAG,
    // Memory port to ring 0 page zero only, never to the stack
    output iee_mem_req_t MEM,
    input wire logic MEM_DONE,
    input wire logic [31:0] MEM_RDATA,
    // Processor state updates
    output logic RING_CROSS,
    output logic PUSH_RET,
    output logic [1:0] FRAME_LEN,
    output logic PSW_CLEAR,
    output logic [31:0] SP_OUT,
    output logic SP_LOAD,
    output logic [31:0] PC_OUT,
    output logic PC_LOAD,
    output logic [31:0] CHAN_ID,
    output logic CHAN_ID_LOAD,
    output logic BUSY
);
    `include "iee_regs.svh"
    // Code 7 of the target select means any CPU, so seven CPUs at most
    if (NCPU < 1 || NCPU > 7 || MY_CPU < 0 || MY_CPU >= NCPU)
    begin
        $error("iee_entry: bad CPU count");
    end
    // ==========================================================
    // Functions
    // ==========================================================
    // Active half of an enable register
    function automatic logic [7:0] half(input logic [15:0] v, input logic rt);
        half = (rt && REALTIME) ? v[15:8] : v[7:0];
    endfunction
    // Lowest pending channel code
    function automatic logic [2:0] first(input logic [7:0] v);
        first = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
            begin
                first = 3'(i);
            end
        end
    endfunction
    // Enable bit of one channel in the active half
    function automatic logic en_bit(input logic [15:0] v, input logic rt, input logic [2:0] n);
        logic [7:0] h;
        h = half(v, rt);
        en_bit = h[n];
    endfunction
    // ==========================================================
    // State
    // ==========================================================
    iee_state_t state_r, state_nxt;
    logic ion_r, realtime_irq_on_flag_r, dsi_prev_r;
    logic [15:0] local_en_r, global_en_r;
    logic [2:0] tgt_r;
    logic [63:0] icr_r;
    logic base_r, vsel_r;
    logic [2:0] chan_r;
    logic [15:0] level_r;
    logic [31:0] sp_r;
    logic [31:0] pc_r, chan_id_r;
    logic [15:0] ack_r;
    // ==========================================================
    // Acceptance
    // ==========================================================
    wire flag_on = (RT_MODE && REALTIME) ? realtime_irq_on_flag_r : ion_r;
    wire [7:0] pend = half(CHAN_PEND, RT_MODE) & half(global_en_r, RT_MODE);
    wire [2:0] pick = first(pend);
    logic [NCPU-1:0] chan_local, grant;
    // Own local enable comes back in on the peer bus, so all CPUs are judged alike
    always_comb
    begin
        for (int c = 0; c < NCPU; c++)
        begin
            chan_local[c] = en_bit(PEER_LOCAL_EN[c], RT_MODE, pick);
        end
    end
    iee_target_pick #(.NCPU(NCPU)) u_pick
    (
        .target_sel(tgt_r),
        .chan_local_en(chan_local),
        .cpu_idle(CPU_IDLE),
        .grant(grant)
    );
    // Broadcast channels go to every locally enabled CPU
    wire bcast = icr_r[`IEE_MODE_LO + pick];
    wire mine = bcast ? chan_local[MY_CPU] : grant[MY_CPU];
    wire take = (state_r == IEE_IDLE) && flag_on && (|pend) && mine;
    wire step = MEM_DONE;
    // ==========================================================
    // Sequencer
    // ==========================================================
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            IEE_IDLE: if (take) state_nxt = (CUR_RING != 2'h0) ? IEE_RING : IEE_LVL_RD;
            IEE_RING: state_nxt = IEE_LVL_RD;
            IEE_LVL_RD: if (step) state_nxt = IEE_LVL_WR;
            IEE_LVL_WR: if (step) state_nxt = IEE_PUSH;
            IEE_PUSH: state_nxt = base_r ? IEE_SAVE_SP : IEE_VEC;
            IEE_SAVE_SP: if (step) state_nxt = IEE_LOAD_SP;
            IEE_LOAD_SP: if (step) state_nxt = IEE_VEC;
            IEE_VEC: if (step) state_nxt = IEE_DONE;
            IEE_DONE: state_nxt = IEE_IDLE;
            default: state_nxt = IEE_IDLE;
        endcase
    end
    // Memory requests; process stack pointer slot is never addressed
    always_comb
    begin
        MEM = '0;
        case (state_r)
            IEE_LVL_RD:
            begin
                MEM.req = 1'b1;
                MEM.addr = `IEE_ADDR_LEVEL;
            end
            IEE_LVL_WR:
            begin
                MEM.req = 1'b1;
                MEM.we = 1'b1;
                MEM.addr = `IEE_ADDR_LEVEL;
                MEM.wdata = {16'h0000, level_r + `IEE_LEVEL_ONE};
            end
            IEE_SAVE_SP:
            begin
                MEM.req = 1'b1;
                MEM.we = 1'b1;
                MEM.addr = `IEE_ADDR_PREV_SP;
                MEM.wdata = sp_r;
            end
            IEE_LOAD_SP:
            begin
                MEM.req = 1'b1;
                MEM.addr = `IEE_ADDR_ISP;
            end
            IEE_VEC:
            begin
                MEM.req = 1'b1;
                MEM.addr = vsel_r ? `IEE_ADDR_VEC_B : `IEE_ADDR_VEC_A;
            end
            default: MEM = '0;
        endcase
    end
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_r <= IEE_IDLE;
            base_r <= 1'b0;
            vsel_r <= 1'b0;
            chan_r <= 3'h0;
            level_r <= `IEE_LEVEL_BASE;
            sp_r <= 32'h0000_0000;
            pc_r <= 32'h0000_0000;
            chan_id_r <= 32'h0000_0000;
            ack_r <= 16'h0000;
        end
        else if (CLK_EN)
        begin
            state_r <= state_nxt;
            ack_r <= 16'h0000;
            if (take)
            begin
                chan_r <= pick;
                vsel_r <= RT_MODE && REALTIME;
                ack_r <= 16'(1) << ({RT_MODE && REALTIME, 3'h0} + 4'(pick));
            end
            if (state_r == IEE_LVL_RD && step)
            begin
                level_r <= MEM_RDATA[15:0];
                base_r <= (MEM_RDATA[15:0] == `IEE_LEVEL_BASE);
            end
            if (state_r == IEE_PUSH)
            begin
                sp_r <= CUR_SP;
                chan_id_r <= {29'h0000_0000, chan_r};
            end
            if (state_r == IEE_LOAD_SP && step)
            begin
                sp_r <= MEM_RDATA;
            end
            if (state_r == IEE_VEC && step)
            begin
                pc_r <= MEM_RDATA;
            end
        end
    end
    // ==========================================================
    // Flags and configuration
    // ==========================================================
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ion_r <= 1'b0;
            realtime_irq_on_flag_r <= 1'b0;
            dsi_prev_r <= 1'b0;
            local_en_r <= `IEE_EN_RST;
            global_en_r <= `IEE_EN_RST;
            tgt_r <= `IEE_TGT_RST;
            icr_r <= `IEE_ICR_RST;
        end
        else if (CLK_EN)
        begin
            // Taking wins over a same-cycle enable so entry stays masked
            if (DSI)
            begin
                dsi_prev_r <= flag_on;
            end
            if (RT_MODE && REALTIME)
            begin
                realtime_irq_on_flag_r <= !(DSI || take) && (ENI || realtime_irq_on_flag_r);
            end
            else
            begin
                ion_r <= !(DSI || take) && (ENI || ion_r);
            end
            case (CFG_WR.op)
                3'h1: local_en_r <= REALTIME ? CFG_WR.data[15:0] : {8'h00, CFG_WR.data[7:0]};
                3'h2: global_en_r <= REALTIME ? CFG_WR.data[15:0] : {8'h00, CFG_WR.data[7:0]};
                3'h3: tgt_r <= CFG_WR.data[2:0];
                3'h4: icr_r <= CFG_WR.data;
                default: icr_r <= icr_r;
            endcase
        end
    end
    // ==========================================================
    // Outputs
    // ==========================================================
    assign CHAN_ACK = ack_r;
    assign DSI_PREV = dsi_prev_r;
    assign LOCAL_EN = local_en_r;
    assign GLOBAL_EN = global_en_r;
    assign TARGET_CPU = tgt_r;
    assign INTERRUPT_CHANNEL_CONTROL = icr_r;
    assign COMPLEX_IRQ_ON_FLAG = ion_r;
    assign REALTIME_IRQ_ON_FLAG = realtime_irq_on_flag_r;
    assign RING_CROSS = (state_r == IEE_RING);
    assign PUSH_RET = (state_r == IEE_PUSH);
    assign FRAME_LEN = `IEE_FRL_EXT;
    assign PSW_CLEAR = (state_r == IEE_PUSH) && base_r;
    assign SP_OUT = sp_r;
    assign SP_LOAD = (state_r == IEE_VEC) && base_r && step;
    assign PC_OUT = pc_r;
    assign PC_LOAD = (state_r == IEE_DONE);
    assign CHAN_ID = chan_id_r;
    assign CHAN_ID_LOAD = (state_r == IEE_DONE);
    assign BUSY = (state_r != IEE_IDLE);
endmodule

// ==== test/iee_entry_props.sv ====
// Port checker of the interrupt entry block
`timescale 1ns/100ps
`include "iee_regs.svh"
module iee_entry_props
    import iee_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Watched ports
    input wire logic [15:0] CHAN_ACK,
    input wire logic RT_MODE,
    input wire logic DSI,
    input wire logic DSI_PREV,
    input wire logic COMPLEX_IRQ_ON_FLAG,
    input wire logic REALTIME_IRQ_ON_FLAG,
    input wire iee_mem_req_t MEM,
    input wire logic MEM_DONE,
    input wire logic [31:0] MEM_RDATA,
    input wire logic PUSH_RET,
    input wire logic PSW_CLEAR,
    input wire logic [1:0] FRAME_LEN,
    input wire logic SP_LOAD,
    input wire logic [31:0] CHAN_ID,
    input wire logic CHAN_ID_LOAD
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    logic [15:0] lvl_r;
    wire logic act = RT_MODE ? REALTIME_IRQ_ON_FLAG : COMPLEX_IRQ_ON_FLAG;
    wire logic lvl_rd = MEM.req && !MEM.we && MEM.addr == `IEE_ADDR_LEVEL;
    // Last level word read, so the write back can be judged
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            lvl_r <= 16'h0000;
        else if (lvl_rd && MEM_DONE)
            lvl_r <= MEM_RDATA[15:0];
    end
    sequence lvl_wr_s;
        MEM.req && MEM.we && MEM.addr == `IEE_ADDR_LEVEL;
    endsequence
    sequence push_s;
        PUSH_RET;
    endsequence
    take_clears_a: assert property (|CHAN_ACK |-> !act)
        else $error("flag still set after take");
    take_needs_on_a: assert property (|CHAN_ACK |-> $past(act))
        else $error("take while flag clear");
    ack_single_a: assert property (|CHAN_ACK |-> $onehot(CHAN_ACK) ##1 !CHAN_ACK)
        else $error("ack not a single pulse");
    level_inc_a: assert property (lvl_wr_s |-> MEM.wdata[15:0] == lvl_r + 16'h0001)
        else $error("level not incremented");
    frame_ext_a: assert property (push_s |-> FRAME_LEN == `IEE_FRL_EXT)
        else $error("frame length wrong at push");
    proc_sp_a: assert property (MEM.req && MEM.we |-> MEM.addr != `IEE_ADDR_PROC_SP)
        else $error("process stack word written");
    chan_id_a: assert property (CHAN_ID_LOAD |-> CHAN_ID[31:3] == 29'h0)
        else $error("channel id upper bits set");
    stack_base_a: assert property (SP_LOAD |-> lvl_r == `IEE_LEVEL_BASE)
        else $error("stack switch at interrupt level");
    psw_clear_a: assert property (push_s |-> PSW_CLEAR == (lvl_r == `IEE_LEVEL_BASE))
        else $error("status clear wrong at push");
    dsi_prev_a: assert property (DSI |=> DSI_PREV == $past(act) && !act)
        else $error("disable result wrong");
endmodule
bind iee_entry iee_entry_props i_props (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .CHAN_ACK(CHAN_ACK), .RT_MODE(RT_MODE), .DSI(DSI), .DSI_PREV(DSI_PREV),
    .COMPLEX_IRQ_ON_FLAG(COMPLEX_IRQ_ON_FLAG), .REALTIME_IRQ_ON_FLAG(REALTIME_IRQ_ON_FLAG), .MEM(MEM), .MEM_DONE(MEM_DONE),
    .MEM_RDATA(MEM_RDATA), .PUSH_RET(PUSH_RET), .FRAME_LEN(FRAME_LEN),
    .SP_LOAD(SP_LOAD), .CHAN_ID(CHAN_ID), .CHAN_ID_LOAD(CHAN_ID_LOAD),
    .PSW_CLEAR(PSW_CLEAR));

// ==== test/iee_mem_model.sv ====
// Ring 0 page zero memory answering the entry block
`timescale 1ns/100ps
module iee_mem_model
    import iee_pkg::*;
(
    // Clock and pace
    input wire logic CORE_CLK,
    input wire logic SLOW,
    // Memory port
    input wire iee_mem_req_t MEM,
    output logic MEM_DONE,
    output logic [31:0] MEM_RDATA
);
    logic [31:0] mem_r [0:31];
    logic [1:0] wait_r = 2'h0;
    logic done_r = 1'h0;
    logic [31:0] rdata_r = 32'h0000_0000;
    assign MEM_DONE = done_r;
    assign MEM_RDATA = rdata_r;
    // Data toggles outside answers so a stale word never looks valid
    always @(posedge CORE_CLK)
    begin
        done_r <= 1'h0;
        rdata_r <= ~rdata_r;
        if (MEM.req && !done_r && wait_r < {SLOW, 1'h0})
            wait_r <= wait_r + 2'h1;
        else if (MEM.req && !done_r)
        begin
            wait_r <= 2'h0;
            done_r <= 1'h1;
            rdata_r <= mem_r[MEM.addr[6:2]];
            if (MEM.we)
                mem_r[MEM.addr[6:2]] <= MEM.wdata;
        end
    end
endmodule

// ==== test/iee_entry_test.sv ====
// Self-checking bench of the interrupt entry block
`timescale 1ns/100ps
module iee_entry_test
    import iee_pkg::*;
;
    logic CORE_CLK = 1'h0, NRST = 1'h0, RT_MODE = 1'h0, ENI = 1'h0, DSI = 1'h0;
    logic SLOW = 1'h0, MEM_DONE, DSI_PREV, COMPLEX_IRQ_ON_FLAG, REALTIME_IRQ_ON_FLAG, PC_LOAD, SP_LOAD, RING_CROSS, BUSY;
    logic [15:0] CHAN_PEND = 16'h0000, peer_en = 16'hFFFF, CHAN_ACK, LOCAL_EN, GLOBAL_EN;
    logic [1:0] CUR_RING = 2'h0, CPU_IDLE = 2'h3;
    logic [31:0] MEM_RDATA, PC_OUT, CHAN_ID, SP_OUT;
    logic [2:0] TARGET_CPU;
    logic [63:0] INTERRUPT_CHANNEL_CONTROL;
    iee_cfg_wr_t CFG_WR = '0;
    iee_mem_req_t MEM;
    wire logic [1:0][15:0] peer = {peer_en, LOCAL_EN};
    int n_fail = 0, cmp_count = 0, n_sp = 0, n_rc = 0;
    always #2 CORE_CLK = ~CORE_CLK;
    always @(negedge CORE_CLK)
    begin
        n_sp += SP_LOAD;
        n_rc += RING_CROSS;
    end
    iee_mem_model i_mem (.CORE_CLK(CORE_CLK), .SLOW(SLOW), .MEM(MEM),
        .MEM_DONE(MEM_DONE), .MEM_RDATA(MEM_RDATA));
    iee_entry #(.NCPU(2), .MY_CPU(0), .REALTIME(1'h1)) i_dut (.CORE_CLK(CORE_CLK),
        .NRST(NRST), .CLK_EN(1'h1), .CHAN_PEND(CHAN_PEND), .CPU_IDLE(CPU_IDLE),
        .PEER_LOCAL_EN(peer), .RT_MODE(RT_MODE), .CUR_RING(CUR_RING),
        .CUR_SP(32'h0000_7F00), .CHAN_ACK(CHAN_ACK), .ENI(ENI), .DSI(DSI),
        .DSI_PREV(DSI_PREV), .CFG_WR(CFG_WR), .LOCAL_EN(LOCAL_EN), .GLOBAL_EN(GLOBAL_EN),
        .TARGET_CPU(TARGET_CPU), .INTERRUPT_CHANNEL_CONTROL(INTERRUPT_CHANNEL_CONTROL), .COMPLEX_IRQ_ON_FLAG(COMPLEX_IRQ_ON_FLAG), .REALTIME_IRQ_ON_FLAG(REALTIME_IRQ_ON_FLAG), .MEM(MEM),
        .MEM_DONE(MEM_DONE), .MEM_RDATA(MEM_RDATA), .RING_CROSS(RING_CROSS),
        .PUSH_RET(), .FRAME_LEN(), .PSW_CLEAR(), .SP_OUT(SP_OUT), .SP_LOAD(SP_LOAD),
        .PC_OUT(PC_OUT), .PC_LOAD(PC_LOAD), .CHAN_ID(CHAN_ID), .CHAN_ID_LOAD(),
        .BUSY(BUSY));
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cfg(input logic [2:0] op, input logic [63:0] d);
        @(posedge CORE_CLK) CFG_WR <= '{op, d};
        @(posedge CORE_CLK) CFG_WR <= '0;
        @(negedge CORE_CLK);
    endtask
    task automatic flag(input logic e, input logic d);
        @(posedge CORE_CLK) {ENI, DSI} <= {e, d};
        @(posedge CORE_CLK) {ENI, DSI} <= 2'h0;
        @(negedge CORE_CLK);
    endtask
    // Any busy cycle in the span counts, so a short entry cannot hide
    task automatic idle_for(input string nm);
        logic seen;
        seen = 1'h0;
        repeat (10)
        begin
            @(negedge CORE_CLK);
            seen = seen | BUSY;
        end
        chk(nm, 1'h0, seen);
    endtask
    // Level preset, one channel raised, whole entry followed to its end
    task automatic take(input int ch, input logic [1:0] rg, input logic [15:0] lv,
        input logic s, input logic [31:0] vec);
        int i;
        i_mem.mem_r[1] = {16'h0000, lv};
        i_mem.mem_r[11] = 32'h5A5A_0000;
        @(posedge CORE_CLK) {CUR_RING, SLOW} <= {rg, s};
        CHAN_PEND[ch] <= 1'h1;
        {n_sp, n_rc, i} = 0;
        @(negedge CORE_CLK);
        while (CHAN_ACK === 16'h0000 && i++ < 20) @(negedge CORE_CLK);
        chk("ack", 16'h0001 << ch, CHAN_ACK);
        chk("flag", 1'h0, RT_MODE ? REALTIME_IRQ_ON_FLAG : COMPLEX_IRQ_ON_FLAG);
        @(posedge CORE_CLK) CHAN_PEND <= 16'h0000;
        while (PC_LOAD !== 1'h1 && i++ < 80) @(negedge CORE_CLK);
        chk("pc", vec, PC_OUT);
        chk("chan id", {29'h0, 3'(ch)}, CHAN_ID);
        while (BUSY !== 1'h0 && i++ < 90) @(negedge CORE_CLK);
        chk("level", lv + 16'h0001, i_mem.mem_r[1][15:0]);
        chk("stack switch", lv == 16'h0000, n_sp);
        chk("ring cross", rg != 2'h0, n_rc);
        chk("prev sp", lv == 16'h0000 ? 32'h0000_7F00 : 32'h5A5A_0000, i_mem.mem_r[11]);
        if (lv == 16'h0000)
            chk("sp", 32'h0000_3C00, SP_OUT);
        chk("proc sp", 32'h1234_5678, i_mem.mem_r[18]);
    endtask
    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #20000;
        n_fail++;
        close_out();
    end
    initial
    begin
        {i_mem.mem_r[2], i_mem.mem_r[4]} = {32'h0000_A000, 32'h0000_B000};
        {i_mem.mem_r[8], i_mem.mem_r[18]} = {32'h0000_3C00, 32'h1234_5678};
        repeat (5) @(posedge CORE_CLK);
        NRST <= 1'h1;
        @(negedge CORE_CLK);
        chk("reset", {3'h7, 1'h0, 32'h0}, {TARGET_CPU, COMPLEX_IRQ_ON_FLAG, LOCAL_EN, GLOBAL_EN});
        chk("icr reset", 64'h0, INTERRUPT_CHANNEL_CONTROL);
        cfg(3'h1, 64'hFFFF);
        chk("local", 16'hFFFF, LOCAL_EN);
        cfg(3'h4, 64'h0000_00A5_0000_0003);
        chk("mode", 8'hA5, INTERRUPT_CHANNEL_CONTROL[39:32]);
        chk("icr", 64'h0000_00A5_0000_0003, INTERRUPT_CHANNEL_CONTROL);
        flag(1'h1, 1'h0);
        chk("eni", 1'h1, COMPLEX_IRQ_ON_FLAG);
        @(posedge CORE_CLK) CHAN_PEND <= 16'h0004;
        idle_for("global mask");
        flag(1'h0, 1'h1);
        chk("dsi", 2'h2, {DSI_PREV, COMPLEX_IRQ_ON_FLAG});
        flag(1'h0, 1'h1);
        chk("dsi again", 2'h0, {DSI_PREV, COMPLEX_IRQ_ON_FLAG});
        cfg(3'h2, 64'hFFFF);
        chk("global", 16'hFFFF, GLOBAL_EN);
        idle_for("deferred");
        @(posedge CORE_CLK) CHAN_PEND <= 16'h0000;
        flag(1'h1, 1'h0);
        take(2, 2'h0, 16'h0000, 1'h0, 32'h0000_A000);
        flag(1'h1, 1'h0);
        take(5, 2'h2, 16'h0001, 1'h1, 32'h0000_A000);
        flag(1'h1, 1'h0);
        take(3, 2'h1, 16'h0000, 1'h1, 32'h0000_A000);
        @(posedge CORE_CLK) RT_MODE <= 1'h1;
        flag(1'h1, 1'h0);
        chk("rt flag", 2'h2, {REALTIME_IRQ_ON_FLAG, COMPLEX_IRQ_ON_FLAG});
        take(9, 2'h0, 16'h0003, 1'h0, 32'h0000_B000);
        @(posedge CORE_CLK) RT_MODE <= 1'h0;
        cfg(3'h3, 64'h1);
        chk("target", 3'h1, TARGET_CPU);
        flag(1'h1, 1'h0);
        @(posedge CORE_CLK) {CHAN_PEND, CPU_IDLE} <= {16'h0008, 2'h2};
        idle_for("other target");
        cfg(3'h3, 64'h7);
        idle_for("other idle");
        @(posedge CORE_CLK) CPU_IDLE <= 2'h3;
        take(3, 2'h0, 16'h0000, 1'h0, 32'h0000_A000);
        close_out();
    end
endmodule
